// File: bench/spm_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module spm_board_model (
    input  wire logic        rst_i,
    input  wire logic [2:0]  strap_cfg_i,
    input  wire logic [15:0] ext_gp_i,
    input  wire logic [15:0] gp_pad_o_i,
    input  wire logic [15:0] gp_pad_oe_n_i,
    input  wire logic [31:0] host_pad_o_i,
    input  wire logic [31:0] host_pad_oe_n_i,
    output logic      [2:0]  strap_o,
    output logic      [15:0] gp_lvl_o,
    output logic      [31:0] host_lvl_o
);
    // ------------------------------------------------------------
    // straps at reset levels in reset, flipped afterwards
    // ------------------------------------------------------------
    assign strap_o    = rst_i ? strap_cfg_i : ~strap_cfg_i;
    assign gp_lvl_o   = (gp_pad_o_i & ~gp_pad_oe_n_i) | (ext_gp_i & gp_pad_oe_n_i);
    assign host_lvl_o = host_pad_o_i ^ host_pad_oe_n_i;
endmodule
`default_nettype wire

// File: bench/spm_pin_mux_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module spm_pin_mux_monitor #(
    parameter int HOST_W   = 32,
    parameter int SHARED_W = 8
) (
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_ack_o,
    input wire logic [31:0]         wb_dat_o,
    input wire logic                width_strap_pin_i,
    input wire logic                atm_select_strap_pin_i,
    input wire logic                pci_enable_strap_i,
    input wire logic                full_width_host_mode_o,
    input wire logic                atm_port_enable_o,
    input wire logic                pci_port_enable_o,
    input wire logic [HOST_W-1:0]   host_port_out_i,
    input wire logic                host_port_oe_i,
    input wire logic [HOST_W-1:0]   host_data_lines_pad_o,
    input wire logic [HOST_W-1:0]   host_data_lines_pad_oe_n_o,
    input wire logic [HOST_W-1:0]   pci_ad_in_o,
    input wire logic [SHARED_W-1:0] sh_pad_oe_n_o,
    input wire logic [SHARED_W-1:0] serial_port_one_oe_i,
    input wire logic [SHARED_W-1:0] atm_oe_i,
    input wire logic [SHARED_W-1:0] atm_in_o
);
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    chk_wb_ack_pulse: assert property (s_wb_req |=> s_ack_pulse)
        else $error("ack not a single pulse after request");
    chk_wb_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    chk_strap_capture: assert property ($fell(rst_i) |->
        {pci_port_enable_o, atm_port_enable_o, full_width_host_mode_o} ==
        $past({pci_enable_strap_i, atm_select_strap_pin_i, width_strap_pin_i}))
        else $error("strap not captured at reset release");
    chk_strap_hold: assert property (1'b1 |=> $stable({pci_port_enable_o,
        atm_port_enable_o, full_width_host_mode_o})) else $error("strap changed");
    chk_half_width_hiz: assert property (!full_width_host_mode_o && !pci_port_enable_o |->
        host_data_lines_pad_oe_n_o[HOST_W-1:16] == '1) else $error("upper lines driven");
    chk_full_width_drive: assert property (!rst_i && full_width_host_mode_o
        && !pci_port_enable_o && host_port_oe_i |=> host_data_lines_pad_oe_n_o == '0 &&
        host_data_lines_pad_o == $past(host_port_out_i)) else $error("host drive wrong");
    chk_pci_in_quiet: assert property (!pci_port_enable_o |-> pci_ad_in_o == '0)
        else $error("pci input not quiet");
    chk_sp1_owns_shared: assert property (!rst_i && !atm_port_enable_o |=>
        sh_pad_oe_n_o == ~$past(serial_port_one_oe_i)) else $error("shared pad not sp1");
    chk_atm_owns_shared: assert property (!rst_i && atm_port_enable_o |=>
        sh_pad_oe_n_o == ~$past(atm_oe_i)) else $error("shared pad not atm");
    chk_atm_in_quiet: assert property (!atm_port_enable_o |-> atm_in_o == '0)
        else $error("atm input not quiet");
endmodule
bind spm_shared_pin_mux spm_pin_mux_monitor #(.HOST_W(HOST_W), .SHARED_W(SHARED_W)) i_mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .width_strap_pin_i(width_strap_pin_i),
    .atm_select_strap_pin_i(atm_select_strap_pin_i), .pci_enable_strap_i(pci_enable_strap_i),
    .full_width_host_mode_o(full_width_host_mode_o), .atm_port_enable_o(atm_port_enable_o),
    .pci_port_enable_o(pci_port_enable_o), .host_port_out_i(host_port_out_i),
    .host_port_oe_i(host_port_oe_i), .host_data_lines_pad_o(host_data_lines_pad_o),
    .host_data_lines_pad_oe_n_o(host_data_lines_pad_oe_n_o), .pci_ad_in_o(pci_ad_in_o),
    .sh_pad_oe_n_o(sh_pad_oe_n_o), .serial_port_one_oe_i(serial_port_one_oe_i),
    .atm_oe_i(atm_oe_i), .atm_in_o(atm_in_o));
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import spm_pkg::*;
;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, host_oe, sclk2;
    logic        width_o, atm_o, pci_o;
    logic [2:0]  cfg, straps;
    logic [3:0]  wb_sel_i, sp1_so_n, sp1_sp;
    logic [6:0]  pci_side_in;
    logic [7:0]  wb_adr_i, oe8, sh_o, sh_oe_n, atm_so_n, pci_so_n, sp1_in, atm_in, atm_sp, pci_sp;
    logic [15:0] ext_gp, gp_lvl, gp_o, gp_oe_n;
    logic [31:0] wb_dat_i, wb_dat_o, pat, host_lvl, host_o, host_oe_n, rd, host_in, pci_ad_in;
    int          err_count, tests_run;
    // ------------------------------------------------------------
    // dut, board and tasks
    // ------------------------------------------------------------
    spm_shared_pin_mux i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .width_strap_pin_i(straps[0]),
        .atm_select_strap_pin_i(straps[1]), .pci_enable_strap_i(straps[2]),
        .gp_pad_i(gp_lvl), .gp_pad_o(gp_o), .gp_pad_oe_n_o(gp_oe_n),
        .cpu_div4_clock_i(pat[20]), .cpu_div6_clock_i(pat[21]),
        .serial_clock_source_two_o(sclk2), .pci_side_out_i(pat[6:0]),
        .pci_side_oe_i(oe8[6:0]), .pci_side_in_o(pci_side_in), .host_data_lines_pad_i(host_lvl),
        .host_data_lines_pad_o(host_o), .host_data_lines_pad_oe_n_o(host_oe_n),
        .host_port_out_i(pat), .host_port_oe_i(host_oe), .host_port_in_o(host_in),
        .pci_ad_out_i(~pat), .pci_ad_oe_i(host_oe), .pci_ad_in_o(pci_ad_in),
        .sh_pad_i(sh_o ^ sh_oe_n), .sh_pad_o(sh_o), .sh_pad_oe_n_o(sh_oe_n),
        .serial_port_one_out_i(pat[7:0]), .serial_port_one_oe_i(oe8),
        .serial_port_one_in_o(sp1_in), .atm_out_i(pat[15:8]), .atm_oe_i(~oe8),
        .atm_in_o(atm_in), .atm_solo_out_i(pat[7:0]), .atm_solo_oe_i(oe8),
        .atm_solo_pad_o(atm_sp), .atm_solo_pad_oe_n_o(atm_so_n), .sp1_solo_out_i(pat[3:0]),
        .sp1_solo_oe_i(oe8[3:0]), .sp1_solo_pad_o(sp1_sp), .sp1_solo_pad_oe_n_o(sp1_so_n),
        .pci_solo_out_i(pat[7:0]), .pci_solo_oe_i(oe8), .pci_solo_pad_o(pci_sp),
        .pci_solo_pad_oe_n_o(pci_so_n), .full_width_host_mode_o(width_o),
        .atm_port_enable_o(atm_o), .pci_port_enable_o(pci_o));
    spm_board_model i_board (
        .rst_i(rst_i), .strap_cfg_i(cfg), .ext_gp_i(ext_gp), .gp_pad_o_i(gp_o),
        .gp_pad_oe_n_i(gp_oe_n), .host_pad_o_i(host_o), .host_pad_oe_n_i(host_oe_n),
        .strap_o(straps), .gp_lvl_o(gp_lvl), .host_lvl_o(host_lvl));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic report_and_stop();
        if (err_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb_xfer(input logic [7:0] a, input logic we, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= 4'h3;
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 20) begin
            err_count++;
            report_and_stop();
        end
    endtask
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {1'b1, 43'h0};
        {wb_sel_i, cfg, pat, oe8, ext_gp, host_oe} = {4'h3, 3'h0, 32'h00a5_c35a, 8'h0f, 16'h0100, 1'b1};
        err_count = 0;
        tests_run = 0;
        for (int c = 0; c < 8; c++) begin
            @(posedge clk_i);
            rst_i <= 1'b1;
            cfg   <= c[2:0];
            repeat (16) @(posedge clk_i);
            rst_i <= 1'b0;
            repeat (3) @(posedge clk_i);
            cmp({29'h0, pci_o, atm_o, width_o}, {29'h0, cfg});
            cmp(host_oe_n, (cfg[2] || cfg[0]) ? 32'h0 : 32'hffff_0000);
            cmp(host_o, cfg[2] ? ~pat : (cfg[0] ? pat : {16'h0, pat[15:0]}));
            cmp({24'h0, sh_oe_n}, {24'h0, cfg[1] ? oe8 : ~oe8});
            cmp({12'h0, sp1_so_n, atm_so_n, pci_so_n}, {12'h0, cfg[1] ? 4'hf : ~oe8[3:0],
                cfg[1] ? ~oe8 : 8'hff, cfg[2] ? ~oe8 : 8'hff});
            cmp({16'h0, gp_oe_n}, {16'h0, cfg[2] ? ~oe8[6:0] : 7'h7f, 9'h1f9});
            cmp({29'h0, gp_o[2:1], sclk2}, {29'h0, pat[21:20], ext_gp[8]});
            cmp(host_in, cfg[2] ? 32'h0 : (cfg[0] ? pat : {16'h0, pat[15:0]}));
            cmp(pci_ad_in, cfg[2] ? ~pat : 32'h0);
            cmp({24'h0, sh_o}, {24'h0, cfg[1] ? pat[15:8] : pat[7:0]});
            cmp({16'h0, sp1_in, atm_in}, {16'h0, cfg[1] ? 8'h00 : (pat[7:0] ^ ~oe8),
                cfg[1] ? (pat[15:8] ^ oe8) : 8'h00});
            cmp({25'h0, pci_side_in}, {25'h0, cfg[2] ? (pat[6:0] & oe8[6:0]) : 7'h00});
            cmp({12'h0, sp1_sp, atm_sp, pci_sp}, {12'h0, cfg[1] ? 4'h0 : pat[3:0],
                cfg[1] ? pat[7:0] : 8'h00, cfg[2] ? pat[7:0] : 8'h00});
            wb_xfer(GPIO_DIRECTION_OFS, 1'b1, 32'h0000_fe02);
            wb_xfer(GPIO_OUTPUT_OFS, 1'b1, 32'h0000_0002);
            wb_xfer(GPIO_ENABLE_OFS, 1'b1, 32'h0000_ff06);
            repeat (2) @(posedge clk_i);
            cmp({16'h0, gp_oe_n}, {16'h0, cfg[2] ? ~oe8[6:0] : 7'h00, 9'h1fd});
            cmp({30'h0, gp_o[1], sclk2}, 32'h2);
            wb_xfer(GPIO_INPUT_OFS, 1'b0, 32'h0);
            cmp(rd, 32'h0000_0100);
            wb_xfer(GPIO_DIRECTION_OFS, 1'b0, 32'h0);
            cmp(rd, 32'h0000_fe02);
            wb_xfer(STRAP_STATUS_OFS, 1'b1, 32'h0000_0007);
            wb_xfer(STRAP_STATUS_OFS, 1'b0, 32'h0);
            cmp(rd, {29'h0, cfg});
            wb_xfer(8'h14, 1'b0, 32'h0);
            cmp(rd, 32'h0);
            wb_xfer(GPIO_ENABLE_OFS, 1'b1, 32'h0);
            repeat (2) @(posedge clk_i);
            cmp({16'h0, gp_oe_n}, {16'h0, cfg[2] ? ~oe8[6:0] : 7'h7f, 9'h1f9});
        end
        report_and_stop();
    end
endmodule
`default_nettype wire

// File: shared/spm_pkg.sv
package spm_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] GPIO_ENABLE_OFS    = 8'h00;
    localparam logic [7:0] GPIO_DIRECTION_OFS = 8'h04;
    localparam logic [7:0] GPIO_OUTPUT_OFS    = 8'h08;
    localparam logic [7:0] GPIO_INPUT_OFS     = 8'h0c;
    localparam logic [7:0] STRAP_STATUS_OFS   = 8'h10;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] GPIO_ENABLE_RST    = 16'h0000;
    localparam logic [15:0] GPIO_DIRECTION_RST = 16'h0000;
    localparam logic [15:0] GPIO_OUTPUT_RST    = 16'h0000;

    // ------------------------------------------------------------
    // strap status fields
    // ------------------------------------------------------------
    localparam int STRAP_WIDTH_BIT = 0;
    localparam int STRAP_ATM_BIT   = 1;
    localparam int STRAP_PCI_BIT   = 2;

    // ------------------------------------------------------------
    // gpio line layout
    // ------------------------------------------------------------
    localparam int          GPIO_LINES       = 16;
    localparam int          DIV4_LINE        = 1;
    localparam int          DIV6_LINE        = 2;
    localparam int          SERIAL_CLOCK_SOURCE_TWO_LINE       = 8;
    localparam int          PCI_FIRST_LINE   = 9;
    localparam int          PCI_LINE_COUNT   = 7;
    localparam logic [15:0] PCI_LINES_MASK   = 16'hfe00;
    localparam int          HALF_HOST_WIDTH  = 16;
    localparam int          FULL_HOST_WIDTH  = 32;

endpackage

// File: src/spm_shared_pin_mux.sv
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module spm_shared_pin_mux
    import spm_pkg::*;
#(
    parameter int HOST_W     = 32,
    parameter int SHARED_W   = 8,
    parameter int ATM_SOLO_W = 8,
    parameter int SP1_SOLO_W = 4,
    parameter int PCI_SOLO_W = 8
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // strap pins
    input  wire logic                  width_strap_pin_i,
    input  wire logic                  atm_select_strap_pin_i,
    input  wire logic                  pci_enable_strap_i,
    // gpio / clock / pci shared pads
    input  wire logic [15:0]           gp_pad_i,
    output logic      [15:0]           gp_pad_o,
    output logic      [15:0]           gp_pad_oe_n_o,
    input  wire logic                  cpu_div4_clock_i,
    input  wire logic                  cpu_div6_clock_i,
    output logic                       serial_clock_source_two_o,
    input  wire logic [6:0]            pci_side_out_i,
    input  wire logic [6:0]            pci_side_oe_i,
    output logic      [6:0]            pci_side_in_o,
    // host data / pci address-data pads
    input  wire logic [HOST_W-1:0]     host_data_lines_pad_i,
    output logic      [HOST_W-1:0]     host_data_lines_pad_o,
    output logic      [HOST_W-1:0]     host_data_lines_pad_oe_n_o,
    input  wire logic [HOST_W-1:0]     host_port_out_i,
    input  wire logic                  host_port_oe_i,
    output logic      [HOST_W-1:0]     host_port_in_o,
    input  wire logic [HOST_W-1:0]     pci_ad_out_i,
    input  wire logic                  pci_ad_oe_i,
    output logic      [HOST_W-1:0]     pci_ad_in_o,
    // serial port one / atm shared pads
    input  wire logic [SHARED_W-1:0]   sh_pad_i,
    output logic      [SHARED_W-1:0]   sh_pad_o,
    output logic      [SHARED_W-1:0]   sh_pad_oe_n_o,
    input  wire logic [SHARED_W-1:0]   serial_port_one_out_i,
    input  wire logic [SHARED_W-1:0]   serial_port_one_oe_i,
    output logic      [SHARED_W-1:0]   serial_port_one_in_o,
    input  wire logic [SHARED_W-1:0]   atm_out_i,
    input  wire logic [SHARED_W-1:0]   atm_oe_i,
    output logic      [SHARED_W-1:0]   atm_in_o,
    // standalone pads
    input  wire logic [ATM_SOLO_W-1:0] atm_solo_out_i,
    input  wire logic [ATM_SOLO_W-1:0] atm_solo_oe_i,
    output logic      [ATM_SOLO_W-1:0] atm_solo_pad_o,
    output logic      [ATM_SOLO_W-1:0] atm_solo_pad_oe_n_o,
    input  wire logic [SP1_SOLO_W-1:0] sp1_solo_out_i,
    input  wire logic [SP1_SOLO_W-1:0] sp1_solo_oe_i,
    output logic      [SP1_SOLO_W-1:0] sp1_solo_pad_o,
    output logic      [SP1_SOLO_W-1:0] sp1_solo_pad_oe_n_o,
    input  wire logic [PCI_SOLO_W-1:0] pci_solo_out_i,
    input  wire logic [PCI_SOLO_W-1:0] pci_solo_oe_i,
    output logic      [PCI_SOLO_W-1:0] pci_solo_pad_o,
    output logic      [PCI_SOLO_W-1:0] pci_solo_pad_oe_n_o,
    // strap state
    output logic                       full_width_host_mode_o,
    output logic                       atm_port_enable_o,
    output logic                       pci_port_enable_o
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (HOST_W != FULL_HOST_WIDTH || SHARED_W < 1 || ATM_SOLO_W < 1 ||
        SP1_SOLO_W < 1 || PCI_SOLO_W < 1) begin : g_bad_param
        $error("unsupported width parameter");
    end

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    logic width_q;
    logic atm_q;
    logic pci_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            width_q <= width_strap_pin_i;
            atm_q   <= atm_select_strap_pin_i;
            pci_q   <= pci_enable_strap_i;
        end
    end
    // held after release regardless of pin level changes

    assign full_width_host_mode_o = width_q;
    assign atm_port_enable_o      = atm_q;
    assign pci_port_enable_o      = pci_q;

    // ------------------------------------------------------------
    // wishbone registers
    // ------------------------------------------------------------
    logic [15:0] en_q;
    logic [15:0] dir_q;
    logic [15:0] out_q;
    logic [15:0] in_q;
    logic        ack_q;
    logic [31:0] dat_q;
    logic        req;

    assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            dat_q <= 32'h0000_0000;
            if (req && !wb_we_i) begin
                case (wb_adr_i)
                    GPIO_ENABLE_OFS:    dat_q <= {16'h0000, en_q};
                    GPIO_DIRECTION_OFS: dat_q <= {16'h0000, dir_q};
                    GPIO_OUTPUT_OFS:    dat_q <= {16'h0000, out_q};
                    GPIO_INPUT_OFS:     dat_q <= {16'h0000, in_q};
                    STRAP_STATUS_OFS:   dat_q <= {29'h0000_0000, pci_q, atm_q, width_q};
                    default:            dat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) r[7:0]  = wd[7:0];
        if (sel[1]) r[15:8] = wd[15:8];
        return r;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_q  <= GPIO_ENABLE_RST;
            dir_q <= GPIO_DIRECTION_RST;
            out_q <= GPIO_OUTPUT_RST;
        end else if (req && wb_we_i) begin
            case (wb_adr_i)
                GPIO_ENABLE_OFS:    en_q  <= merge16(en_q, wb_dat_i, wb_sel_i);
                GPIO_DIRECTION_OFS: dir_q <= merge16(dir_q, wb_dat_i, wb_sel_i);
                GPIO_OUTPUT_OFS:    out_q <= merge16(out_q, wb_dat_i, wb_sel_i);
                default:            ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // gpio / clock / pci line mux
    // ------------------------------------------------------------
    logic [15:0] gp_o_d;
    logic [15:0] gp_oe_n_d;
    logic [15:0] gp_in_d;
    logic [6:0]  pci_in_d;
    logic        serial_clock_source_two_d;

    for (genvar i = 0; i < GPIO_LINES; i++) begin : g_line
        logic own_gpio;
        logic alt_o;
        logic alt_oe;
        assign own_gpio = en_q[i] & ~(PCI_LINES_MASK[i] & pci_q);
        if (i == DIV4_LINE) begin : g_d4
            assign alt_o  = cpu_div4_clock_i;
            assign alt_oe = 1'b1;
        end else if (i == DIV6_LINE) begin : g_d6
            assign alt_o  = cpu_div6_clock_i;
            assign alt_oe = 1'b1;
        end else if (i >= PCI_FIRST_LINE) begin : g_pci
            assign alt_o  = pci_side_out_i[i-PCI_FIRST_LINE];
            assign alt_oe = pci_side_oe_i[i-PCI_FIRST_LINE] & pci_q;
        end else begin : g_none
            assign alt_o  = 1'b0;
            assign alt_oe = 1'b0;
        end
        assign gp_o_d[i]    = own_gpio ? out_q[i] : (alt_oe ? alt_o : 1'b0);
        assign gp_oe_n_d[i] = own_gpio ? ~dir_q[i] : ~alt_oe;
        assign gp_in_d[i]   = own_gpio & ~dir_q[i] & gp_pad_i[i];
        if (i >= PCI_FIRST_LINE) begin : g_pin
            assign pci_in_d[i-PCI_FIRST_LINE] = pci_q & gp_pad_i[i];
        end
    end

    assign serial_clock_source_two_d = ~en_q[SERIAL_CLOCK_SOURCE_TWO_LINE] & gp_pad_i[SERIAL_CLOCK_SOURCE_TWO_LINE];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gp_pad_o                  <= 16'h0000;
            gp_pad_oe_n_o             <= 16'hffff;
            in_q                      <= 16'h0000;
            pci_side_in_o             <= 7'h00;
            serial_clock_source_two_o <= 1'b0;
        end else begin
            gp_pad_o                  <= gp_o_d;
            gp_pad_oe_n_o             <= gp_oe_n_d;
            in_q                      <= gp_in_d;
            pci_side_in_o             <= pci_in_d;
            serial_clock_source_two_o <= serial_clock_source_two_d;
        end
    end

    // ------------------------------------------------------------
    // host / pci data lines
    // ------------------------------------------------------------
    logic [HOST_W-1:0] used_mask;
    assign used_mask = (width_q | pci_q) ? {HOST_W{1'b1}}
                                         : {{(HOST_W-HALF_HOST_WIDTH){1'b0}},
                                            {HALF_HOST_WIDTH{1'b1}}};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            host_data_lines_pad_o      <= '0;
            host_data_lines_pad_oe_n_o <= '1;
            host_port_in_o             <= '0;
            pci_ad_in_o                <= '0;
        end else if (pci_q) begin
            host_data_lines_pad_o      <= pci_ad_out_i;
            host_data_lines_pad_oe_n_o <= {HOST_W{~pci_ad_oe_i}};
            host_port_in_o             <= '0;
            pci_ad_in_o                <= host_data_lines_pad_i;
        end else begin
            host_data_lines_pad_o      <= host_port_out_i & used_mask;
            host_data_lines_pad_oe_n_o <= ~({HOST_W{host_port_oe_i}} & used_mask);
            host_port_in_o             <= host_data_lines_pad_i & used_mask;
            pci_ad_in_o                <= '0;
        end
    end

    // ------------------------------------------------------------
    // serial port one / atm and standalone pads
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sh_pad_o             <= '0;
            sh_pad_oe_n_o        <= '1;
            serial_port_one_in_o <= '0;
            atm_in_o             <= '0;
        end else if (atm_q) begin
            sh_pad_o             <= atm_out_i;
            sh_pad_oe_n_o        <= ~atm_oe_i;
            atm_in_o             <= sh_pad_i;
            serial_port_one_in_o <= '0;
        end else begin
            sh_pad_o             <= serial_port_one_out_i;
            sh_pad_oe_n_o        <= ~serial_port_one_oe_i;
            serial_port_one_in_o <= sh_pad_i;
            atm_in_o             <= '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            atm_solo_pad_o      <= '0;
            atm_solo_pad_oe_n_o <= '1;
            sp1_solo_pad_o      <= '0;
            sp1_solo_pad_oe_n_o <= '1;
            pci_solo_pad_o      <= '0;
            pci_solo_pad_oe_n_o <= '1;
        end else begin
            atm_solo_pad_o      <= atm_q ? atm_solo_out_i : '0;
            atm_solo_pad_oe_n_o <= ~(atm_solo_oe_i & {ATM_SOLO_W{atm_q}});
            sp1_solo_pad_o      <= atm_q ? '0 : sp1_solo_out_i;
            sp1_solo_pad_oe_n_o <= ~(sp1_solo_oe_i & {SP1_SOLO_W{~atm_q}});
            pci_solo_pad_o      <= pci_q ? pci_solo_out_i : '0;
            pci_solo_pad_oe_n_o <= ~(pci_solo_oe_i & {PCI_SOLO_W{pci_q}});
        end
    end

endmodule
`default_nettype wire
